// file: stx_bit_counter.sv
`timescale 1ns/100ps
`default_nettype none

module stx_bit_counter
    import stx_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // framer side
    stx_cnt_if.counter cnt
);

    stx_cnt_s st_ff; // registered state
    stx_cnt_s nxt_st; // next state
    logic at_last; // final bit on the line

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        at_last = st_ff.busy && (st_ff.index == st_ff.len - 5'h01);
        // carry out on the edge that finishes the final bit
        cnt.overflow = cnt.edge_stb && at_last;
        if (cnt.edge_stb) begin
            if (cnt.load) begin
                // load mode, wins over the overflow when both fall on the same edge
                nxt_st.index = 5'h00;
                nxt_st.len = cnt.length;
                nxt_st.busy = 1'b1;
            end else if (at_last) begin
                // nothing queued, line goes quiet
                nxt_st.busy = 1'b0;
            end else if (st_ff.busy) begin
                nxt_st.index = st_ff.index + 5'h01;
            end
        end
        cnt.index = st_ff.index;
        cnt.busy = st_ff.busy;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

// file: stx_checker.sv
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// port-level checks of bus handshake and line events
// ---------------------------------------------------------------
module stx_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // line and transfer
    input wire logic tx_clock_pin,
    input wire logic serial_data_out,
    input wire logic data_valid,
    input wire logic data_load,
    input wire logic block_check_start,
    input wire logic char_end
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // every access starts with exactly one wait cycle
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait cycle on a new access");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access waited more than one cycle");
    a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait raised with no access");
    // registers are at most 16 bits wide
    a_rdata_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    // events are one-cycle strobes tied to a line clock edge
    a_load_pulse: assert property (data_load |-> data_valid ##1 !data_load)
        else $error("load strobe wrong");
    a_end_pulse: assert property (char_end |=> !char_end)
        else $error("character end longer than one cycle");
    a_end_on_edge: assert property (char_end |-> $past(tx_clock_pin, 2))
        else $error("character end away from a line edge");
    a_serial_on_edge: assert property ($changed(serial_data_out) |-> $past(tx_clock_pin, 3))
        else $error("serial output moved away from a line edge");
    // early end flag only moves with a word load
    a_early_on_load: assert property ($changed(block_check_start) |-> $past(data_load))
        else $error("early end changed without a load");
endmodule

bind sync_tx_idle_parity_early_end stx_checker chk_u (.clock, .rst_n, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .tx_clock_pin, .serial_data_out, .data_valid,
    .data_load, .block_check_start, .char_end);

`default_nettype wire

// file: stx_cnt_if.sv
`timescale 1ns/100ps
`default_nettype none

// carrier between framer and its bit counter
interface stx_cnt_if;
    logic edge_stb; // synchronised transmit clock rising edge
    logic load; // start a new character on this edge
    logic [4:0] length; // bits in the new character
    logic [4:0] index; // bit position now on the line
    logic busy; // a character is being shifted
    logic overflow; // final bit done, one-cycle strobe

    modport counter (
        input edge_stb, load, length,
        output index, busy, overflow
    );
    modport user (
        output edge_stb, load, length,
        input index, busy, overflow
    );
endinterface

`default_nettype wire

// file: stx_line_model.sv
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// modem side: makes the transmit clock, samples the line
// ---------------------------------------------------------------
module stx_line_model (
    // control
    input wire logic run,
    // line
    input wire logic serial_in,
    output logic line_clock,
    output logic [31:0] hist
);
    // 200 ns clock, phase offset from the system clock; stands low when stopped
    initial begin
        line_clock = 1'b0;
        hist = 32'h0;
        #37;
        forever #100 line_clock = run & ~line_clock;
    end

    // newest bit enters at the top, so a finished character sits left-aligned
    always @(posedge line_clock) begin
        hist <= {serial_in, hist[31:1]};
    end
endmodule

`default_nettype wire

// file: stx_map.svh
`ifndef STX_MAP_SVH
`define STX_MAP_SVH

// ---------------------------------------------------------------
// register word addresses (avalon word addressing)
// ---------------------------------------------------------------
`define STX_ADDR_CTRL 2'h0
`define STX_ADDR_SYNC 2'h1
`define STX_ADDR_ESC 2'h2
`define STX_ADDR_STAT 2'h3

// ---------------------------------------------------------------
// control register field positions
// ---------------------------------------------------------------
`define STX_CTRL_GO 0
`define STX_CTRL_IDLE 1
`define STX_CTRL_TRANSP 2
`define STX_CTRL_PAR_EN 3
`define STX_CTRL_PAR_ODD 4
`define STX_CTRL_DOUBLE 5
`define STX_CTRL_BLKCHK 6
`define STX_CTRL_BITS_LO 8
`define STX_CTRL_BITS_HI 11

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define STX_CTRL_RST 12'h800
`define STX_SYNC_RST 16'h0016
`define STX_ESC_RST 16'h0010

// ---------------------------------------------------------------
// character geometry
// ---------------------------------------------------------------
`define STX_MAX_BITS 5'h10
`define STX_BYTE_BITS 5'h08

`endif

// file: stx_pkg.sv
package stx_pkg;

    // source of the character being serialised
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_SYNC,
        SRC_ESC,
        SRC_DATA_LO,
        SRC_DATA_HI
    } stx_src_e;

    // bit counter state
    typedef struct packed {
        logic [4:0] index;
        logic [4:0] len;
        logic busy;
    } stx_cnt_s;

    // framer state
    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_prev;
        logic ack;
        logic [31:0] rdata;
        logic [11:0] ctrl;
        logic [15:0] sync_char;
        logic [15:0] esc_char;
        stx_src_e src;
        logic [15:0] shift;
        logic [15:0] word;
        logic [4:0] char_len;
        logic alt_flag;
        logic toggle;
        logic hold;
        logic odd_latch;
        logic early_end;
        logic pending_high;
        logic tx_active;
        logic serial;
    } stx_top_s;

endpackage

// file: stx_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "stx_map.svh"

module tb;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic clock, rst_n, avs_read, avs_write, avs_waitrequest, run;
    logic [1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, hist;
    logic tx_clock_pin, serial_data_out, data_valid, data_load;
    logic tx_cycle, byte_count_odd, block_check_start, char_end;
    logic [15:0] data_word;
    int mismatches, num_checks;
    int cycles = 0;

    sync_tx_idle_parity_early_end dut_u (.clock, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .tx_clock_pin, .serial_data_out,
        .data_word, .data_valid, .data_load, .tx_cycle, .byte_count_odd,
        .escape_request(1'b0), .block_check_start, .char_end);
    stx_line_model line_u (.run, .serial_in(serial_data_out), .line_clock(tx_clock_pin), .hist);

    always #12.5 clock = ~clock;

    // hang guard: whole run is under two thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            report_and_stop;
        end
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one access; read data land in q
    task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        // hold everything until an edge samples waitrequest low
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // wait for a load strobe (ld) or a character end, bounded
    task automatic wait_for(input logic ld);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while ((ld ? data_load : char_end) !== 1'b1 && n < 2000);
        if (n >= 2000) chk(32'h0, 32'h1);
        @(posedge clock);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs;
        bus(1'b0, `STX_ADDR_CTRL, 32'h0);
        chk(q, 32'(`STX_CTRL_RST));
        bus(1'b0, `STX_ADDR_SYNC, 32'h0);
        chk(q, 32'(`STX_SYNC_RST));
        bus(1'b0, `STX_ADDR_ESC, 32'h0);
        chk(q, 32'(`STX_ESC_RST));
        // status is read only; a write must not disturb the flag
        bus(1'b1, `STX_ADDR_STAT, 32'h0);
        bus(1'b0, `STX_ADDR_STAT, 32'h0);
        chk(32'(q[0]), 32'h1);
        $display("registers done");
    endtask

    task automatic t_idle_plain;
        bus(1'b1, `STX_ADDR_SYNC, 32'h5a);
        bus(1'b1, `STX_ADDR_CTRL, 32'h802);
        wait_for(1'b0);
        repeat (3) begin
            wait_for(1'b0);
            chk(32'(hist[31:24]), 32'h5a);
        end
        bus(1'b0, `STX_ADDR_STAT, 32'h0);
        chk(32'(q[0]), 32'h1);
        $display("plain idle done");
    endtask

    // flag stayed set, so escape follows the sync now on the line
    task automatic t_idle_transp;
        bus(1'b1, `STX_ADDR_CTRL, 32'h806);
        wait_for(1'b0);
        for (int i = 0; i < 4; i++) begin
            wait_for(1'b0);
            chk(32'(hist[31:24]), i[0] ? 32'h5a : 32'h10);
        end
        bus(1'b1, `STX_ADDR_CTRL, 32'h800);
        wait_for(1'b0);
        $display("transparent idle done");
    endtask

    task automatic t_parity;
        logic [15:0] w;
        logic odd, par;
        for (int i = 0; i < 4; i++) begin
            w = i[1] ? 16'h6e : 16'h15;
            odd = i[0];
            bus(1'b1, `STX_ADDR_CTRL, 32'h709 | (32'(odd) << 4));
            data_word <= w;
            data_valid <= 1'b1;
            wait_for(1'b1);
            data_valid <= 1'b0;
            // a mark (low) is added when the mark count misses the sense
            par = ~(^(~w[6:0]) ^ odd);
            wait_for(1'b0);
            chk(32'(hist[31:24]), 32'({par, w[6:0]}));
            @(negedge clock);
            chk(32'(serial_data_out), 32'h1);
        end
        $display("parity done");
    endtask

    task automatic t_double;
        int seen;
        bus(1'b1, `STX_ADDR_CTRL, 32'h821);
        data_word <= 16'h3c81;
        data_valid <= 1'b1;
        wait_for(1'b1);
        data_valid <= 1'b0;
        wait_for(1'b0);
        chk(32'(hist[31:24]), 32'h81);
        wait_for(1'b0);
        chk(32'(hist[31:24]), 32'h3c);
        chk(32'(block_check_start), 32'h0);
        tx_cycle <= 1'b1;
        byte_count_odd <= 1'b1;
        @(posedge clock);
        tx_cycle <= 1'b0;
        byte_count_odd <= 1'b0;
        bus(1'b0, `STX_ADDR_STAT, 32'h0);
        chk(32'(q[1]), 32'h1);
        data_word <= 16'ha5c3;
        data_valid <= 1'b1;
        wait_for(1'b1);
        data_valid <= 1'b0;
        @(negedge clock);
        chk(32'(block_check_start), 32'h1);
        wait_for(1'b0);
        chk(32'(hist[31:24]), 32'hc3);
        // the empty high byte must not take a character slot
        seen = 0;
        repeat (200) begin
            @(negedge clock);
            if (char_end === 1'b1) seen++;
        end
        chk(32'(seen), 32'h0);
        bus(1'b0, `STX_ADDR_STAT, 32'h0);
        chk(32'(q[1]), 32'h0);
        $display("double done");
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 2'h0;
        avs_writedata = 32'h0;
        data_word = 16'h0;
        data_valid = 1'b0;
        tx_cycle = 1'b0;
        byte_count_odd = 1'b0;
        run = 1'b1;
        mismatches = 0;
        num_checks = 0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_regs;
        t_idle_plain;
        t_idle_transp;
        t_parity;
        t_double;
        report_and_stop;
    end
endmodule

`default_nettype wire

// file: sync_tx_idle_parity_early_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "stx_map.svh"

module sync_tx_idle_parity_early_end
    import stx_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // line side
    input wire logic tx_clock_pin,
    output logic serial_data_out,
    // transfer side
    input wire logic [15:0] data_word,
    input wire logic data_valid,
    output logic data_load,
    input wire logic tx_cycle,
    input wire logic byte_count_odd,
    input wire logic escape_request,
    // block check and character events
    output logic block_check_start,
    output logic char_end
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    stx_top_s st_ff; // registered state
    stx_top_s nxt_st; // next state
    stx_cnt_if cnt(); // counter carrier
    logic tx_edge; // rising edge of the line clock
    logic start; // new character begins this edge
    logic ovf; // current character done
    logic flag_new; // alternation flag after this edge
    logic early_new; // early end after a load
    stx_src_e pick; // source for the next character
    logic [15:0] next_word; // bits of the next character
    logic [4:0] next_len; // length of the next character
    logic [4:0] bit_pos; // bit position going out
    logic [15:0] shift_new; // shift register after this edge
    logic out_bit; // data bit going out
    logic is_data; // current character carries data
    logic par_slot; // parity position on this edge
    logic tog_base; // toggle before counting this bit
    logic access; // bus request pending

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // data bits per character from the control field, zero means 16
    function automatic logic [4:0] stx_data_bits(input logic [11:0] c);
        logic [4:0] b;
        b = {1'b0, c[`STX_CTRL_BITS_HI:`STX_CTRL_BITS_LO]};
        if (b == 5'h00) begin
            b = `STX_MAX_BITS;
        end
        return b;
    endfunction

    // character length including a parity bit, clipped at 16
    function automatic logic [4:0] stx_char_len(input logic [11:0] c, input logic dat);
        logic [4:0] n;
        n = stx_data_bits(c);
        if (dat && c[`STX_CTRL_PAR_EN] && n < `STX_MAX_BITS) begin
            n = n + 5'h01;
        end
        if (dat && c[`STX_CTRL_DOUBLE] && n > `STX_BYTE_BITS) begin
            n = `STX_BYTE_BITS;
        end
        return n;
    endfunction

    // ---------------------------------------------------------------
    // bit counter
    // ---------------------------------------------------------------
    stx_bit_counter u_cnt (
        .clock(clock),
        .rst_n(rst_n),
        .cnt(cnt.counter)
    );

    // ---------------------------------------------------------------
    // next state of the framer
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        data_load = 1'b0;
        pick = SRC_NONE;
        next_word = 16'h0000;
        next_len = 5'h01;
        bit_pos = 5'h00;
        shift_new = st_ff.shift;
        out_bit = 1'b1;
        par_slot = 1'b0;
        tog_base = st_ff.toggle;
        early_new = st_ff.early_end;

        // line clock passes two flops before it is looked at
        nxt_st.clk_s1 = tx_clock_pin;
        nxt_st.clk_s2 = st_ff.clk_s1;
        nxt_st.clk_prev = st_ff.clk_s2;
        // edge turned into a single-cycle strobe
        tx_edge = st_ff.clk_s2 && !st_ff.clk_prev;
        ovf = cnt.overflow;
        start = tx_edge && (!cnt.busy || ovf);
        is_data = (st_ff.src == SRC_DATA_LO) || (st_ff.src == SRC_DATA_HI);

        // bus slave, one wait cycle then the answer
        access = avs_read || avs_write;
        nxt_st.ack = access && !st_ff.ack;
        // write lands on the edge that sees waitrequest low, as the master expects
        if (access && st_ff.ack) begin
            if (avs_write) begin
                unique case (avs_address)
                    `STX_ADDR_CTRL: nxt_st.ctrl = avs_writedata[11:0];
                    `STX_ADDR_SYNC: nxt_st.sync_char = avs_writedata[15:0];
                    `STX_ADDR_ESC: nxt_st.esc_char = avs_writedata[15:0];
                    `STX_ADDR_STAT: nxt_st.ctrl = st_ff.ctrl;
                endcase
            end
        end
        // read data registered during the wait cycle, so it stands at the answer
        if (access && !st_ff.ack) begin
            unique case (avs_address)
                `STX_ADDR_CTRL: nxt_st.rdata = {20'h00000, st_ff.ctrl};
                `STX_ADDR_SYNC: nxt_st.rdata = {16'h0000, st_ff.sync_char};
                `STX_ADDR_ESC: nxt_st.rdata = {16'h0000, st_ff.esc_char};
                `STX_ADDR_STAT: begin
                    nxt_st.rdata = {24'h000000, st_ff.serial, st_ff.pending_high,
                        cnt.busy, st_ff.tx_active, st_ff.hold, st_ff.early_end,
                        st_ff.odd_latch, st_ff.alt_flag};
                end
            endcase
        end

        // alternation flag at the end of an idle character
        flag_new = st_ff.alt_flag;
        if (ovf && st_ff.src == SRC_ESC) begin
            flag_new = 1'b0;
        end else if (ovf && st_ff.src == SRC_SYNC) begin
            // any mode: d input held high after a sync, flag set; only an escape end clears it
            flag_new = 1'b1;
        end
        nxt_st.alt_flag = flag_new;

        // choose the next source, data before escape before idle
        if (start) begin
            if (st_ff.pending_high && !st_ff.early_end) begin
                pick = SRC_DATA_HI;
            end else if (st_ff.ctrl[`STX_CTRL_GO] && data_valid) begin
                pick = SRC_DATA_LO;
            end else if (escape_request) begin
                pick = SRC_ESC;
            end else if (st_ff.ctrl[`STX_CTRL_IDLE]) begin
                if (st_ff.ctrl[`STX_CTRL_TRANSP] && flag_new) begin
                    pick = SRC_ESC;
                end else begin
                    pick = SRC_SYNC;
                end
            end
        end

        // load of the shift holding register doubles as load-sync clear
        if (pick == SRC_DATA_LO) begin
            data_load = 1'b1;
            nxt_st.word = data_word;
            // early end takes the latch, latch clears
            early_new = st_ff.odd_latch;
            nxt_st.odd_latch = 1'b0;
            nxt_st.early_end = early_new;
            // high byte queued only when the count is even
            nxt_st.pending_high = st_ff.ctrl[`STX_CTRL_DOUBLE] && !early_new;
        end else if (pick == SRC_DATA_HI) begin
            nxt_st.pending_high = 1'b0;
        end

        // odd count arrives during the transfer cycle, set wins over clear
        if (tx_cycle && byte_count_odd) begin
            nxt_st.odd_latch = 1'b1;
        end

        // bits of the chosen character
        unique case (pick)
            SRC_SYNC: next_word = st_ff.sync_char;
            SRC_ESC: next_word = st_ff.esc_char;
            SRC_DATA_LO: next_word = data_word;
            SRC_DATA_HI: next_word = {8'h00, st_ff.word[15:8]};
            SRC_NONE: next_word = 16'h0000;
        endcase
        next_len = stx_char_len(st_ff.ctrl,
            (pick == SRC_DATA_LO) || (pick == SRC_DATA_HI));
        if (st_ff.ctrl[`STX_CTRL_DOUBLE] && pick != SRC_NONE && next_len > `STX_BYTE_BITS) begin
            next_len = `STX_BYTE_BITS;
        end

        // serialise: load on start, shift on the other edges
        if (start) begin
            nxt_st.src = pick;
            if (pick != SRC_NONE) begin
                shift_new = next_word;
                nxt_st.char_len = next_len;
                bit_pos = 5'h00;
            end
            // running state follows the kind of character
            nxt_st.tx_active = (pick == SRC_DATA_LO) || (pick == SRC_DATA_HI);
        end else if (tx_edge && cnt.busy) begin
            shift_new = {1'b1, st_ff.shift[15:1]};
            bit_pos = cnt.index + 5'h01;
        end
        if (tx_edge) begin
            nxt_st.shift = shift_new;
        end

        // what goes on the line this edge; idle line rests at space
        if (tx_edge) begin
            if (start && pick == SRC_NONE) begin
                out_bit = 1'b1;
            end else begin
                out_bit = shift_new[0];
            end
            par_slot = st_ff.ctrl[`STX_CTRL_PAR_EN] && nxt_st.tx_active &&
                (bit_pos == nxt_st.char_len - 5'h01) && !(start && pick == SRC_NONE);
            // toggle restarts at each character
            tog_base = ovf ? 1'b0 : st_ff.toggle;
            if (par_slot) begin
                // marks so far xor sense: one means a mark is due
                nxt_st.hold = tog_base ^ st_ff.ctrl[`STX_CTRL_PAR_ODD];
                nxt_st.toggle = tog_base;
                if (!st_ff.ctrl[`STX_CTRL_BLKCHK]) begin
                    // mark is a low level on the inner side
                    out_bit = !nxt_st.hold;
                end
            end else begin
                // flips on every mark (low) bit sent
                nxt_st.toggle = tog_base ^ !out_bit;
            end
            nxt_st.serial = out_bit;
        end else if (ovf) begin
            nxt_st.toggle = 1'b0;
        end
        // not running: held clear
        if (!nxt_st.tx_active) begin
            nxt_st.toggle = 1'b0;
        end

        // outputs
        char_end = ovf;
        block_check_start = st_ff.early_end;
        serial_data_out = st_ff.serial;
        avs_readdata = st_ff.rdata;
        avs_waitrequest = access && !st_ff.ack;
        cnt.edge_stb = tx_edge;
        cnt.load = start && (pick != SRC_NONE);
        cnt.length = next_len;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.ctrl <= `STX_CTRL_RST;
            st_ff.sync_char <= `STX_SYNC_RST;
            st_ff.esc_char <= `STX_ESC_RST;
            st_ff.src <= SRC_NONE;
            st_ff.serial <= 1'b1;
            // idle always begins from a known flag state
            st_ff.alt_flag <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire
